// File: msq_params.svh
`ifndef MSQ_PARAMS_SVH
`define MSQ_PARAMS_SVH
// ----------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------
`define MSQ_A_CTRL 8'h00
`define MSQ_A_INJ_FREQ 8'h04
`define MSQ_A_BLOCK_TIME 8'h08
`define MSQ_A_INJ_TIME 8'h0C
`define MSQ_A_INJ_LEVEL 8'h10
`define MSQ_A_DWELL 8'h14
`define MSQ_A_TARGET 8'h18
`define MSQ_A_VBUS_THR 8'h1C
`define MSQ_A_STATUS 8'h20
// ----------------------------------------------------------------------
// Fields, limits and reset values
// ----------------------------------------------------------------------
`define MSQ_MODE_W 3
`define MSQ_STALL_BIT 4
`define MSQ_MODE_MAX 3'h4
`define MSQ_MODE_RAMP 3'h0
`define MSQ_MODE_DC 3'h1
`define MSQ_MODE_COAST 3'h2
`define MSQ_MODE_POWER 3'h4
`define MSQ_FREQ_MAX 16'h1770
`define MSQ_TIME_MAX 16'h1770
`define MSQ_LEVEL_MAX 8'hC8
`define MSQ_INJ_FREQ_RST 16'h01F4
`define MSQ_BLOCK_TIME_RST 16'h000A
`define MSQ_INJ_TIME_RST 16'h0064
`define MSQ_INJ_LEVEL_RST 8'h32
`define MSQ_TARGET_RST 16'h1770
`define MSQ_VBUS_THR_RST 12'hC00
`define MSQ_RAMP_STEP_RST 16'h000A
// ----------------------------------------------------------------------
// Timing: one timer tick is 10 ms, clock period 40 ns
// ----------------------------------------------------------------------
`define MSQ_TICK_NS 10000000
`define MSQ_CLK_NS 40
`endif

// File: msq_pkg.sv
package msq_pkg;
  // --------------------------------------------------------------------
  // Sequencer states
  // --------------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_RUN, ST_DECEL, ST_DWELL, ST_BLOCK, ST_INJECT
  } msq_state_e;

  // --------------------------------------------------------------------
  // Drive command to the output stage
  // --------------------------------------------------------------------
  typedef struct packed {
    logic out_en;
    logic inj_on;
    logic [7:0] inj_level;
    logic [15:0] freq;
  } msq_drive_s;
endpackage : msq_pkg

// File: msq_stop_seq.sv
// Implementation choices: the register addresses and the APB slave port.
`timescale 1ns/10ps
`include "msq_params.svh"
// Summary of operation
// - Stop mode selector accepts values 0 to 4 only.
// - Stop mode selector resets to 0, plain ramp-down stop.
// - Ramp stop lowers frequency along the ramp to 0 Hz, then stops.
// - DC stop ramps down, then injects DC at the braking frequency.
// - Injection start frequency 0.00 to 60.00 Hz, default 5.00 Hz.
// - Output blocked 0.00 to 60.00 s, default 0.10 s, before injection.
// - Injection lasts 0 to 60 s, default 1.00 s, then braking ends.
// - Injection level 0 to 200 percent of rated current, default 50.
// - Dwell below braking frequency is skipped; injection starts instead.
// - Coast mode 2 cuts output at once when run is removed.
// - Power braking mode 4 holds or raises frequency on high bus voltage.
// - Power braking and stall prevention act only while decelerating.
// - Power braking wins over stall prevention when both are enabled.
module msq_stop_seq #(
  parameter int TICK_CYC = `MSQ_TICK_NS / `MSQ_CLK_NS,
  parameter logic [15:0] RAMP_STEP = `MSQ_RAMP_STEP_RST
) (
  input wire logic ref_clk,
  input wire logic srst,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_cmd,
  input wire logic [11:0] vbus_level,
  input wire logic stall_req,
  output msq_pkg::msq_drive_s drive,
  output logic pb_active,
  output logic stall_active
);
  import msq_pkg::*;

  localparam int TW = $clog2(TICK_CYC + 1);

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [15:0] clamp16(input logic [15:0] v,
                                          input logic [15:0] lim);
    clamp16 = (v > lim) ? lim : v;
  endfunction : clamp16

  function automatic logic [15:0] sat_sub(input logic [15:0] a,
                                          input logic [15:0] b);
    sat_sub = (a > b) ? a - b : 16'h0000;
  endfunction : sat_sub

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  logic [2:0] stop_mode_q, stop_mode_d;
  logic stall_en_q, stall_en_d;
  logic [15:0] inj_freq_q, inj_freq_d;
  logic [15:0] block_time_q, block_time_d;
  logic [15:0] inj_time_q, inj_time_d;
  logic [7:0] inj_level_q, inj_level_d;
  logic [15:0] dwell_freq_q, dwell_freq_d;
  logic [15:0] dwell_time_q, dwell_time_d;
  logic [15:0] target_q, target_d;
  logic [11:0] vbus_thr_q, vbus_thr_d;
  logic [31:0] prdata_q, prdata_d;
  logic pready_q, pready_d;
  logic pslverr_q, pslverr_d;
  msq_state_e state_q, state_d;
  logic [15:0] freq_q, freq_d;
  logic [15:0] cnt_q, cnt_d;
  logic [TW-1:0] tick_cnt_q, tick_cnt_d;
  logic dwell_done_q, dwell_done_d;
  msq_drive_s drive_q, drive_d;
  logic tick;
  logic dwell_ok;
  logic wr_en;
  logic rd_en;
  logic addr_hit;

  // --------------------------------------------------------------------
  // APB slave: one wait state, data registered
  // --------------------------------------------------------------------
  assign wr_en = psel && penable && pready_q && pwrite;
  assign rd_en = psel && penable && !pready_q && !pwrite;
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // Decode against the map; anything else answers with pslverr
  always_comb
  begin
    case (paddr)
      `MSQ_A_CTRL, `MSQ_A_INJ_FREQ, `MSQ_A_BLOCK_TIME, `MSQ_A_INJ_TIME,
      `MSQ_A_INJ_LEVEL, `MSQ_A_DWELL, `MSQ_A_TARGET, `MSQ_A_VBUS_THR,
      `MSQ_A_STATUS: addr_hit = 1'b1;
      default: addr_hit = 1'b0;
    endcase
  end

  // Register writes, read data and the handshake
  always_comb
  begin
    stop_mode_d = stop_mode_q;
    stall_en_d = stall_en_q;
    inj_freq_d = inj_freq_q;
    block_time_d = block_time_q;
    inj_time_d = inj_time_q;
    inj_level_d = inj_level_q;
    dwell_freq_d = dwell_freq_q;
    dwell_time_d = dwell_time_q;
    target_d = target_q;
    vbus_thr_d = vbus_thr_q;
    prdata_d = prdata_q;
    pready_d = psel && penable && !pready_q;
    pslverr_d = psel && penable && !pready_q && !addr_hit;
    if (wr_en)
    begin
      case (paddr)
        `MSQ_A_CTRL:
        begin
          // Out-of-range selector values are dropped, old mode kept
          if (pwdata[`MSQ_MODE_W-1:0] <= `MSQ_MODE_MAX)
            stop_mode_d = pwdata[`MSQ_MODE_W-1:0];
          stall_en_d = pwdata[`MSQ_STALL_BIT];
        end
        `MSQ_A_INJ_FREQ: inj_freq_d =
          clamp16(pwdata[15:0], `MSQ_FREQ_MAX);
        `MSQ_A_BLOCK_TIME: block_time_d =
          clamp16(pwdata[15:0], `MSQ_TIME_MAX);
        `MSQ_A_INJ_TIME: inj_time_d =
          clamp16(pwdata[15:0], `MSQ_TIME_MAX);
        `MSQ_A_INJ_LEVEL: inj_level_d =
          (pwdata[7:0] > `MSQ_LEVEL_MAX) ? `MSQ_LEVEL_MAX
                                         : pwdata[7:0];
        `MSQ_A_DWELL:
        begin
          dwell_freq_d = clamp16(pwdata[15:0], `MSQ_FREQ_MAX);
          dwell_time_d = clamp16(pwdata[31:16], `MSQ_TIME_MAX);
        end
        `MSQ_A_TARGET: target_d = clamp16(pwdata[15:0], `MSQ_FREQ_MAX);
        `MSQ_A_VBUS_THR: vbus_thr_d = pwdata[11:0];
        default: ;
      endcase
    end
    if (rd_en)
    begin
      case (paddr)
        `MSQ_A_CTRL: prdata_d = {27'h0, stall_en_q, 1'b0, stop_mode_q};
        `MSQ_A_INJ_FREQ: prdata_d = {16'h0, inj_freq_q};
        `MSQ_A_BLOCK_TIME: prdata_d = {16'h0, block_time_q};
        `MSQ_A_INJ_TIME: prdata_d = {16'h0, inj_time_q};
        `MSQ_A_INJ_LEVEL: prdata_d = {24'h0, inj_level_q};
        `MSQ_A_DWELL: prdata_d = {dwell_time_q, dwell_freq_q};
        `MSQ_A_TARGET: prdata_d = {16'h0, target_q};
        `MSQ_A_VBUS_THR: prdata_d = {20'h0, vbus_thr_q};
        `MSQ_A_STATUS: prdata_d = {freq_q, 9'h0, stall_active,
          pb_active, drive_q.inj_on, drive_q.out_en, state_q};
        default: prdata_d = 32'h0;
      endcase
    end
  end

  // --------------------------------------------------------------------
  // Stop sequencer
  // --------------------------------------------------------------------
  // Timers advance in 10 ms ticks to keep the counters narrow
  assign tick = (tick_cnt_q == TW'(TICK_CYC - 1));

  // In DC mode, dwell only when it sits at or above the injection point
  assign dwell_ok = (dwell_time_q != 16'h0000) &&
    ((stop_mode_q != `MSQ_MODE_DC) || (dwell_freq_q >= inj_freq_q));

  // Braking aids only while ramping down; power braking masks stall
  assign pb_active = (state_q == ST_DECEL) &&
    (stop_mode_q == `MSQ_MODE_POWER) && (vbus_level > vbus_thr_q);
  assign stall_active = (state_q == ST_DECEL) && stall_en_q &&
    stall_req && !pb_active;

  // Next state, frequency and timers
  always_comb
  begin
    state_d = state_q;
    freq_d = freq_q;
    cnt_d = cnt_q;
    dwell_done_d = dwell_done_q;
    tick_cnt_d = tick ? '0 : tick_cnt_q + TW'(1);
    case (state_q)
      ST_IDLE:
      begin
        freq_d = 16'h0000;
        dwell_done_d = 1'b0;
        if (run_cmd)
          state_d = ST_RUN;
      end
      ST_RUN:
      begin
        if (tick)
          freq_d = (freq_q < target_q)
            ? clamp16(freq_q + RAMP_STEP, target_q)
            : sat_sub(freq_q, RAMP_STEP);
        if (!run_cmd)
        begin
          if (stop_mode_q == `MSQ_MODE_COAST)
          begin
            // Output dropped at once, load left to coast
            state_d = ST_IDLE;
            freq_d = 16'h0000;
          end
          else
            state_d = ST_DECEL;
        end
      end
      ST_DECEL:
      begin
        if (run_cmd && stop_mode_q != `MSQ_MODE_DC)
          state_d = ST_RUN;
        else if (dwell_ok && !dwell_done_q && freq_q <= dwell_freq_q)
        begin
          state_d = ST_DWELL;
          cnt_d = 16'h0000;
        end
        else if (stop_mode_q == `MSQ_MODE_DC && freq_q <= inj_freq_q)
        begin
          state_d = ST_BLOCK;
          cnt_d = 16'h0000;
        end
        else if (freq_q == 16'h0000)
          state_d = ST_IDLE;
        else if (tick)
        begin
          // Regeneration: climb back one step instead of braking
          if (pb_active)
            freq_d = clamp16(freq_q + RAMP_STEP, target_q);
          else if (!stall_active)
            freq_d = sat_sub(freq_q, RAMP_STEP);
        end
      end
      ST_DWELL:
      begin
        if (cnt_q >= dwell_time_q)
        begin
          state_d = ST_DECEL;
          dwell_done_d = 1'b1;
        end
        else if (tick)
          cnt_d = cnt_q + 16'h0001;
      end
      ST_BLOCK:
      begin
        // Let motor flux decay before DC is applied
        freq_d = 16'h0000;
        if (cnt_q >= block_time_q)
        begin
          state_d = ST_INJECT;
          cnt_d = 16'h0000;
        end
        else if (tick)
          cnt_d = cnt_q + 16'h0001;
      end
      ST_INJECT:
      begin
        if (cnt_q >= inj_time_q)
          state_d = ST_IDLE;
        else if (tick)
          cnt_d = cnt_q + 16'h0001;
      end
      default: state_d = ST_IDLE;
    endcase
  end

  // Drive word follows the next state so it lines up with state_q
  always_comb
  begin
    drive_d.freq = freq_d;
    drive_d.out_en = (state_d == ST_RUN) || (state_d == ST_DECEL) ||
      (state_d == ST_DWELL);
    drive_d.inj_on = (state_d == ST_INJECT);
    // Next level value, so a write during injection stays in step
    drive_d.inj_level = (state_d == ST_INJECT) ? inj_level_d
                                                : 8'h00;
  end

  assign drive = drive_q;

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (srst)
    begin
      stop_mode_q <= `MSQ_MODE_RAMP;
      stall_en_q <= 1'b0;
      inj_freq_q <= `MSQ_INJ_FREQ_RST;
      block_time_q <= `MSQ_BLOCK_TIME_RST;
      inj_time_q <= `MSQ_INJ_TIME_RST;
      inj_level_q <= `MSQ_INJ_LEVEL_RST;
      dwell_freq_q <= 16'h0000;
      dwell_time_q <= 16'h0000;
      target_q <= `MSQ_TARGET_RST;
      vbus_thr_q <= `MSQ_VBUS_THR_RST;
      prdata_q <= 32'h0;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      state_q <= ST_IDLE;
      freq_q <= 16'h0000;
      cnt_q <= 16'h0000;
      tick_cnt_q <= '0;
      dwell_done_q <= 1'b0;
      drive_q <= '0;
    end
    else if (ce)
    begin
      stop_mode_q <= stop_mode_d;
      stall_en_q <= stall_en_d;
      inj_freq_q <= inj_freq_d;
      block_time_q <= block_time_d;
      inj_time_q <= inj_time_d;
      inj_level_q <= inj_level_d;
      dwell_freq_q <= dwell_freq_d;
      dwell_time_q <= dwell_time_d;
      target_q <= target_d;
      vbus_thr_q <= vbus_thr_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      state_q <= state_d;
      freq_q <= freq_d;
      cnt_q <= cnt_d;
      tick_cnt_q <= tick_cnt_d;
      dwell_done_q <= dwell_done_d;
      drive_q <= drive_d;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (srst);

  property p_mode_legal;
    stop_mode_q <= `MSQ_MODE_MAX;
  endproperty
  a_mode_legal: assert property (p_mode_legal)
    else $error("stop mode out of range");

  property p_mode_reset;
    $fell(srst) |-> stop_mode_q == `MSQ_MODE_RAMP;
  endproperty
  a_mode_reset: assert property (p_mode_reset)
    else $error("stop mode not ramp after reset");

  property p_ramp_end;
    ce && state_q == ST_DECEL && !run_cmd && freq_q == 16'h0000 &&
      stop_mode_q != `MSQ_MODE_DC && !(dwell_ok && !dwell_done_q)
      |=> state_q == ST_IDLE && !drive_q.out_en;
  endproperty
  a_ramp_end: assert property (p_ramp_end)
    else $error("ramp stop did not end at zero");

  property p_dc_entry;
    ce && state_q == ST_DECEL && stop_mode_q == `MSQ_MODE_DC &&
      freq_q <= inj_freq_q && !(dwell_ok && !dwell_done_q &&
      freq_q <= dwell_freq_q) |=> state_q == ST_BLOCK;
  endproperty
  a_dc_entry: assert property (p_dc_entry)
    else $error("braking frequency reached without block");

  property p_block_quiet;
    state_q == ST_BLOCK |-> !drive_q.out_en && !drive_q.inj_on;
  endproperty
  a_block_quiet: assert property (p_block_quiet)
    else $error("output live during block interval");

  property p_inj_end;
    ce && state_q == ST_INJECT && cnt_q >= inj_time_q
      |=> state_q == ST_IDLE ##0 !drive_q.inj_on;
  endproperty
  a_inj_end: assert property (p_inj_end)
    else $error("injection ran past its time");

  property p_inj_level;
    drive_q.inj_on |-> drive_q.inj_level == inj_level_q &&
      inj_level_q <= `MSQ_LEVEL_MAX;
  endproperty
  a_inj_level: assert property (p_inj_level)
    else $error("injection level wrong");

  property p_coast;
    ce && state_q == ST_RUN && !run_cmd && stop_mode_q == `MSQ_MODE_COAST
      |=> !drive_q.out_en && drive_q.freq == 16'h0000;
  endproperty
  a_coast: assert property (p_coast)
    else $error("coast did not cut output");

  property p_pb_hold;
    ce && tick && pb_active && state_d == ST_DECEL
      |=> freq_q >= $past(freq_q);
  endproperty
  a_pb_hold: assert property (p_pb_hold)
    else $error("frequency fell under power braking");

  property p_aids_decel;
    (pb_active || stall_active) |-> state_q == ST_DECEL && !(pb_active &&
      stall_active);
  endproperty
  a_aids_decel: assert property (p_aids_decel)
    else $error("braking aid outside deceleration");

  c_coast: cover property (state_q == ST_RUN && !run_cmd &&
    stop_mode_q == `MSQ_MODE_COAST);
  c_inject: cover property (state_q == ST_BLOCK ##1 state_q == ST_INJECT);
  c_pb: cover property (pb_active);
  c_dwell: cover property (state_q == ST_DWELL);
endmodule : msq_stop_seq

// File: msq_motor_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------------
// Output stage and motor as seen from the sequencer
// ----------------------------------------------------------------------
module msq_motor_model (
  input wire logic ref_clk,
  input wire logic srst,
  input wire msq_pkg::msq_drive_s drive,
  input wire logic regen_cmd,
  input wire logic stall_cmd,
  output logic [11:0] vbus_level,
  output logic stall_req
);
  import msq_pkg::*;
  logic [11:0] vbus_d;
  logic stall_d;

  // Regeneration only lifts the bus while the bridge is switching
  always_comb
  begin
    vbus_d = (drive.out_en && !drive.inj_on && regen_cmd) ? 12'hD00 : 12'h800;
    stall_d = drive.out_en && stall_cmd;
  end

  // Registered: the bus sample and current limit arrive a cycle late
  always_ff @(posedge ref_clk)
  begin
    vbus_level <= srst ? 12'h800 : vbus_d;
    stall_req <= srst ? 1'b0 : stall_d;
  end
endmodule : msq_motor_model

// File: motor_stop_sequencer_tb_top.sv
`timescale 1ns/10ps
`include "msq_params.svh"
module motor_stop_sequencer_tb_top;
  import msq_pkg::*;
  // --------------------------------------------------------------------
  // Signals and constants
  // --------------------------------------------------------------------
  localparam int TICK = 4;
  localparam logic [31:0] RST_TAB [8] = '{32'h0, 32'h1F4, 32'hA, 32'h64,
    32'h32, 32'h0, 32'h1770, 32'hC00};
  localparam logic [31:0] MODES [2] = '{32'h0, 32'h3};
  logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
  logic run_cmd, regen_cmd, stall_cmd, stall_req, pb_active, stall_active;
  logic ce;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [11:0] vbus_level;
  logic rerr;
  msq_drive_s drive;
  int err_total = 0;
  int check_count = 0;

  msq_stop_seq #(.TICK_CYC(TICK), .RAMP_STEP(16'h000A)) dut (
    .ref_clk(ref_clk), .srst(srst), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_cmd(run_cmd), .vbus_level(vbus_level), .stall_req(stall_req),
    .drive(drive), .pb_active(pb_active), .stall_active(stall_active));

  msq_motor_model motor (.ref_clk(ref_clk), .srst(srst), .drive(drive),
    .regen_cmd(regen_cmd), .stall_cmd(stall_cmd),
    .vbus_level(vbus_level), .stall_req(stall_req));

  // 25 MHz reference clock
  initial
  begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end

  // --------------------------------------------------------------------
  // Reporting and bus tasks
  // --------------------------------------------------------------------
  task automatic close_out;
    $display("mismatches %0d, comparisons %0d", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : close_out

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tmo(input int n, input int lim);
    if (n >= lim)
    begin
      err_total++;
      $display("unexpected at %0t: wait limit reached", $time);
      close_out();
    end
  endtask : tmo

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    @(posedge ref_clk);
    n = 1;
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge ref_clk);
      n++;
    end
    rd = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    tmo(n, 20);
  endtask : apb

  // Output flags picked by number so one bounded wait serves all
  function automatic logic probe(input int which);
    case (which)
      0: return drive.out_en;
      1: return drive.inj_on;
      2: return pb_active;
      3: return stall_active;
      5: return drive.freq <= 16'h003C;
      default: return drive.freq === 16'h0064;
    endcase
  endfunction : probe

  task automatic wait_for(input int which, input logic val, input int lim);
    int n;
    n = 0;
    while (probe(which) !== val && n < lim)
    begin
      @(posedge ref_clk);
      n++;
    end
    tmo(n, lim);
  endtask : wait_for

  task automatic run_up;
    @(posedge ref_clk);
    run_cmd <= 1'b1;
    wait_for(4, 1'b1, 400);
  endtask : run_up

  // Stop with DC braking; returns cycles from stop to injection
  task automatic dc_stop(output int n);
    int nb;
    int ni;
    logic [15:0] lastf;
    n = 0;
    nb = 0;
    ni = 0;
    lastf = 16'h0;
    run_up();
    run_cmd <= 1'b0;
    while (drive.inj_on !== 1'b1 && n < 400)
    begin
      @(posedge ref_clk);
      n++;
      if (drive.out_en === 1'b1)
        lastf = drive.freq;
      else if (drive.inj_on === 1'b0)
        nb++;
    end
    tmo(n, 400);
    chk(32'(lastf <= 16'h0032 && lastf >= 16'h0028), 32'h1);
    chk(32'(nb >= 4 && nb <= 12), 32'h1);
    chk(32'(drive.inj_level), 32'h40);
    while (drive.inj_on === 1'b1 && ni < 400)
    begin
      @(posedge ref_clk);
      ni++;
    end
    tmo(ni, 400);
    chk(32'(ni >= 8 && ni <= 16), 32'h1);
    chk(32'({drive.out_en, drive.inj_on}), 32'h0);
  endtask : dc_stop

  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    int n;
    int n2;
    int bad;
    logic [15:0] last;
    logic [15:0] f;
    {psel, penable, pwrite, run_cmd, regen_cmd, stall_cmd} = 6'h0;
    ce = 1'b1;
    paddr = 8'h0;
    pwdata = 32'h0;
    srst = 1'b1;
    repeat (10) @(posedge ref_clk);
    srst <= 1'b0;
    // Reset values, then refused and clamped writes
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, RST_TAB[i]);
    end
    apb(1'b0, 8'h24, 32'h0);
    chk({rd[30:0], rerr}, 32'h1);
    apb(1'b1, `MSQ_A_STATUS, 32'hFFFFFFFF);
    apb(1'b0, `MSQ_A_STATUS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, `MSQ_A_CTRL, 32'h1);
    apb(1'b1, `MSQ_A_CTRL, 32'h5);
    apb(1'b0, `MSQ_A_CTRL, 32'h0);
    chk(rd, 32'h1);
    apb(1'b1, `MSQ_A_INJ_LEVEL, 32'hFF);
    apb(1'b0, `MSQ_A_INJ_LEVEL, 32'h0);
    chk(rd, 32'hC8);
    apb(1'b1, `MSQ_A_INJ_FREQ, 32'hFFFF);
    apb(1'b0, `MSQ_A_INJ_FREQ, 32'h0);
    chk(rd, 32'h1770);
    apb(1'b1, `MSQ_A_VBUS_THR, 32'hABC);
    apb(1'b0, `MSQ_A_VBUS_THR, 32'h0);
    chk(rd, 32'hABC);
    apb(1'b1, `MSQ_A_VBUS_THR, 32'hC00);
    // Short profile keeps ramps and braking phases to tens of cycles
    apb(1'b1, `MSQ_A_TARGET, 32'h64);
    apb(1'b1, `MSQ_A_INJ_FREQ, 32'h32);
    apb(1'b1, `MSQ_A_BLOCK_TIME, 32'h2);
    apb(1'b1, `MSQ_A_INJ_TIME, 32'h3);
    apb(1'b1, `MSQ_A_INJ_LEVEL, 32'h40);
    // Ramp stop, also under the reserved code
    foreach (MODES[i])
    begin
      apb(1'b1, `MSQ_A_CTRL, MODES[i]);
      apb(1'b0, `MSQ_A_CTRL, 32'h0);
      chk(rd, MODES[i]);
      run_up();
      run_cmd <= 1'b0;
      n = 0;
      bad = 0;
      last = 16'h0064;
      while (drive.out_en !== 1'b0 && n < 400)
      begin
        @(posedge ref_clk);
        n++;
        if (drive.freq > last)
          bad++;
        last = drive.freq;
      end
      tmo(n, 400);
      chk(32'(n >= 36 && bad == 0), 32'h1);
      chk(32'(drive.freq), 32'h0);
    end
    // Coast: output cut on the edge after run is withdrawn
    apb(1'b1, `MSQ_A_CTRL, 32'h2);
    run_up();
    run_cmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(32'({drive.out_en, drive.freq}), 32'h0);
    // DC braking, then again with a dwell below the braking frequency
    apb(1'b1, `MSQ_A_CTRL, 32'h1);
    dc_stop(n);
    apb(1'b1, `MSQ_A_DWELL, 32'h0005001E);
    dc_stop(n2);
    chk(32'(n2 <= n + 4 && n2 + 4 >= n), 32'h1);
    // Dwell at or above the braking frequency must add its hold time
    apb(1'b1, `MSQ_A_DWELL, 32'h0005003C);
    dc_stop(n2);
    chk(32'(n2 >= n + 16), 32'h1);
    apb(1'b1, `MSQ_A_DWELL, 32'h0);
    // Power braking with stall prevention also enabled
    apb(1'b1, `MSQ_A_CTRL, 32'h14);
    run_up();
    stall_cmd <= 1'b1;
    regen_cmd <= 1'b1;
    repeat (4) @(posedge ref_clk);
    chk(32'({pb_active, stall_active}), 32'h0);
    stall_cmd <= 1'b0;
    regen_cmd <= 1'b0;
    repeat (2) @(posedge ref_clk);
    run_cmd <= 1'b0;
    wait_for(5, 1'b1, 100);
    stall_cmd <= 1'b1;
    wait_for(3, 1'b1, 20);
    f = drive.freq;
    repeat (12) @(posedge ref_clk);
    chk(32'(drive.freq), 32'(f));
    regen_cmd <= 1'b1;
    wait_for(2, 1'b1, 20);
    chk(32'(stall_active), 32'h0);
    f = drive.freq;
    repeat (12) @(posedge ref_clk);
    chk(32'(drive.freq > f), 32'h1);
    stall_cmd <= 1'b0;
    regen_cmd <= 1'b0;
    // Clock enable low must freeze the ramp where it stands
    ce <= 1'b0;
    @(posedge ref_clk);
    f = drive.freq;
    repeat (12) @(posedge ref_clk);
    chk(32'(drive.freq), 32'(f));
    ce <= 1'b1;
    wait_for(0, 1'b0, 400);
    chk(32'(drive.freq), 32'h0);
    close_out();
  end
endmodule : motor_stop_sequencer_tb_top
